// >>> hw/span_reset_device.sv
// Device end: span selection, reset behaviour and conversion timing
// Function
// - span pin high at busy fall: narrow span
// - span pin low at busy fall: wide span
// - hardware mode samples span only on busy fall
// - software mode takes span from control bits
// - device stays in reset while reset high
// - software reset aborts conversion, clears control bits
// - hardware reset configures mode from hw_sw_select pin only; span pin waits for busy fall
// - host gives one 100 ns reset after power-up
// - trigger may stay high through reset
// - trigger low in reset needs full pulse
// - hardware reset only between conversions
`timescale 1ns/1ps
`default_nettype none
module span_reset_device
#(
    parameter int unsigned CONV_CYCLES = span_reset_pkg::CONV_CYCLES_DEFAULT
)
(
    input  wire logic   clk_sys_i,
    input  wire logic   rst_i,
    span_reset_if.device_mp pins,
    output logic [2:0]  span_active_o,
    output logic        sw_mode_o,
    output logic [2:0]  converting_o
);
    localparam int unsigned NP = span_reset_pkg::PAIR_COUNT;

    // Refuse settings the 16-bit timer or the 3-bit pin bundle cannot serve
    if (CONV_CYCLES < 2 || CONV_CYCLES > 65535)
    begin : g_bad_conv_cycles
        $error("CONV_CYCLES out of range");
    end
    if (NP != 3)
    begin : g_bad_pair_count
        $error("PAIR_COUNT must match the three trigger pins");
    end

    logic [NP-1:0] ctrl_span_reg;
    logic          hw_span_reg;
    logic          sw_mode_reg;
    logic [NP-1:0] start;
    logic [15:0]   count_reg [NP];
    logic [NP-1:0] busy_pair_reg;
    logic          busy_reg;
    logic          busy_fall;
    logic [NP-1:0] span_active_reg;

    // True at the very edge that lowers the busy pin
    assign busy_fall = busy_reg && !(|busy_pair_reg);

    // Mode latched from the select pin while reset is high
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            sw_mode_reg <= 1'h0;
        else if (pins.reset_pin)
            sw_mode_reg <= pins.hw_sw_select;
    end

    // Software control span bits
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            ctrl_span_reg <= span_reset_pkg::CTRL_RESET_VALUE;
        else if (pins.reset_pin)
            ctrl_span_reg <= span_reset_pkg::CTRL_RESET_VALUE;
        else if (sw_mode_reg && pins.ctrl_span_write)
            ctrl_span_reg <= pins.ctrl_span_bits;
    end

    // Span pin is looked at only when busy falls
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            hw_span_reg <= span_reset_pkg::SPAN_RESET_VALUE;
        else if (busy_fall)
            hw_span_reg <= pins.span_select ? span_reset_pkg::SPAN_NARROW
                                            : span_reset_pkg::SPAN_WIDE;
    end

    genvar g;
    generate
        for (g = 0; g < NP; g = g + 1)
        begin : g_pair
            trigger_arm u_arm (
                .clk_sys_i (clk_sys_i),
                .rst_i     (rst_i),
                .in_reset_i(pins.reset_pin),
                .trigger_i (pins.conversion_trigger_x[g]),
                .start_o   (start[g])
            );

            // Conversion timer per pair, aborted by reset
            always_ff @(posedge clk_sys_i)
            begin
                if (rst_i || pins.reset_pin)
                begin
                    busy_pair_reg[g] <= 1'h0;
                    count_reg[g]     <= 16'h0;
                end
                else if (start[g] && !busy_pair_reg[g])
                begin
                    busy_pair_reg[g] <= 1'h1;
                    count_reg[g]     <= 16'(CONV_CYCLES - 1);
                end
                else if (busy_pair_reg[g])
                begin
                    if (count_reg[g] == 16'h0)
                        busy_pair_reg[g] <= 1'h0;
                    else
                        count_reg[g] <= count_reg[g] - 16'h1;
                end
            end

            // Span applied to this pair: fixed between busy falls in hardware mode, follows the control bits in software mode
            always_ff @(posedge clk_sys_i)
            begin
                if (rst_i)
                    span_active_reg[g] <= span_reset_pkg::SPAN_RESET_VALUE;
                else if (sw_mode_reg)
                    span_active_reg[g] <= ctrl_span_reg[g];
                else
                    span_active_reg[g] <= hw_span_reg;
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            busy_reg <= 1'h0;
        else
            busy_reg <= |busy_pair_reg;
    end

    assign pins.busy     = busy_reg;
    assign span_active_o = span_active_reg;
    assign sw_mode_o     = sw_mode_reg;
    assign converting_o  = busy_pair_reg;
endmodule : span_reset_device
`default_nettype wire

// >>> hw/span_reset_host.sv
// Host end: drives reset, mode, span and trigger pins from software registers
`timescale 1ns/1ps
`default_nettype none
module span_reset_host
#(
    parameter int unsigned RESET_CYCLES = span_reset_pkg::RESET_PULSE_CYCLES
)
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    span_reset_if.host_mp    pins
);
    // The pulse counter is eight bits wide
    if (RESET_CYCLES < 1 || RESET_CYCLES > 255)
    begin : g_bad_reset_cycles
        $error("RESET_CYCLES out of range");
    end

    logic [7:0]  rst_cnt_reg;
    logic        reset_pin_reg;
    logic        mode_reg;
    logic        span_reg;
    logic [2:0]  trig_reg;
    logic [2:0]  span_bits_reg;
    logic        span_wr_reg;
    logic        busy_seen_reg;
    logic        reset_req;
    logic [31:0] rdata_reg;

    // Reset is allowed only with busy low
    assign reset_req = wr_i && addr_i == span_reset_pkg::ADDR_CTRL
                       && wdata_i[span_reset_pkg::CTRL_RESET_BIT] && !pins.busy;

    // Power-up pulse starts during own reset and outlasts it; software may repeat it
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            reset_pin_reg <= 1'h1;
            rst_cnt_reg   <= 8'(RESET_CYCLES);
        end
        else if (reset_req)
        begin
            reset_pin_reg <= 1'h1;
            rst_cnt_reg   <= 8'(RESET_CYCLES);
        end
        else if (rst_cnt_reg != 8'h0)
            rst_cnt_reg <= rst_cnt_reg - 8'h1;
        else
            reset_pin_reg <= 1'h0;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            mode_reg <= 1'h0;
            span_reg <= 1'h0;
            trig_reg <= 3'h7;
        end
        else if (wr_i && addr_i == span_reset_pkg::ADDR_CTRL)
        begin
            mode_reg <= wdata_i[span_reset_pkg::CTRL_MODE_BIT];
            span_reg <= wdata_i[span_reset_pkg::CTRL_SPAN_BIT];
            trig_reg <= wdata_i[span_reset_pkg::CTRL_TRIG_LSB +: 3];
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            span_bits_reg <= 3'h0;
            span_wr_reg   <= 1'h0;
        end
        else
        begin
            span_wr_reg <= wr_i && addr_i == span_reset_pkg::ADDR_SPAN;
            if (wr_i && addr_i == span_reset_pkg::ADDR_SPAN)
                span_bits_reg <= wdata_i[2:0];
        end
    end

    // Sticky busy-seen flag, cleared by a status read; set wins
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            busy_seen_reg <= 1'h0;
        else if (pins.busy)
            busy_seen_reg <= 1'h1;
        else if (rd_i && addr_i == span_reset_pkg::ADDR_STATUS)
            busy_seen_reg <= 1'h0;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            rdata_reg <= 32'h0;
        else if (rd_i)
        begin
            unique case (addr_i)
                span_reset_pkg::ADDR_CTRL:
                    rdata_reg <= {25'h0, trig_reg, 1'h0, span_reg, mode_reg, reset_pin_reg};
                span_reset_pkg::ADDR_STATUS:
                    rdata_reg <= {30'h0, busy_seen_reg, pins.busy};
                span_reset_pkg::ADDR_SPAN:
                    rdata_reg <= {29'h0, span_bits_reg};
                default:
                    rdata_reg <= 32'h0;
            endcase
        end
        else
            rdata_reg <= 32'h0;
    end

    assign rdata_o                   = rdata_reg;
    assign pins.reset_pin            = reset_pin_reg;
    assign pins.hw_sw_select         = mode_reg;
    assign pins.span_select          = span_reg;
    assign pins.conversion_trigger_x = trig_reg;
    assign pins.ctrl_span_bits       = span_bits_reg;
    assign pins.ctrl_span_write      = span_wr_reg;
endmodule : span_reset_host
`default_nettype wire

// >>> hw/span_reset_if.sv
// Pin bundle between the converter control device and its host
`timescale 1ns/1ps
`default_nettype none
interface span_reset_if;
    logic       reset_pin;
    logic       hw_sw_select;
    logic       span_select;
    logic [2:0] conversion_trigger_x;
    logic [2:0] ctrl_span_bits;
    logic       ctrl_span_write;
    logic       busy;

    modport device_mp (
        input  reset_pin,
        input  hw_sw_select,
        input  span_select,
        input  conversion_trigger_x,
        input  ctrl_span_bits,
        input  ctrl_span_write,
        output busy
    );

    modport host_mp (
        output reset_pin,
        output hw_sw_select,
        output span_select,
        output conversion_trigger_x,
        output ctrl_span_bits,
        output ctrl_span_write,
        input  busy
    );
endinterface : span_reset_if
`default_nettype wire

// >>> hw/span_reset_pkg.sv
// Shared constants and types for the span-select and reset control pair
package span_reset_pkg;
    // Number of channel pairs, each with its own trigger and span bit
    localparam int unsigned PAIR_COUNT = 3;
    // Span encodings: 1 selects the narrow span (2 x ref), 0 the wide span (4 x ref)
    localparam logic SPAN_NARROW = 1'h1;
    localparam logic SPAN_WIDE   = 1'h0;
    // Control-register value after a software-mode reset
    localparam logic [PAIR_COUNT-1:0] CTRL_RESET_VALUE = 3'h0;
    // Span held after system reset (rst_i) until the first busy falling edge
    localparam logic SPAN_RESET_VALUE = 1'h0;
    // Reset pulse width and conversion time
    localparam int unsigned RESET_PULSE_NS    = 100;
    localparam int unsigned CLK_PERIOD_NS     = 8;
    localparam int unsigned RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CONV_CYCLES_DEFAULT = 400;
    // Software port offsets of the host controller
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_SPAN   = 4'h2;
    // Control register field positions
    localparam int unsigned CTRL_RESET_BIT   = 0;
    localparam int unsigned CTRL_MODE_BIT    = 1;
    localparam int unsigned CTRL_SPAN_BIT    = 2;
    localparam int unsigned CTRL_TRIG_LSB    = 4;
    localparam logic [31:0] CTRL_REG_RESET   = 32'h0;
    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_BUSY
    } conv_state_t;
endpackage : span_reset_pkg

// >>> hw/trigger_arm.sv
// Per-pair conversion trigger arming after reset and rising-edge start detection
`timescale 1ns/1ps
`default_nettype none
module trigger_arm
(
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    input  wire logic in_reset_i,
    input  wire logic trigger_i,
    output logic      start_o
);
    logic trigger_prev_reg;
    logic armed_reg;

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            trigger_prev_reg <= 1'h0;
        else
            trigger_prev_reg <= trigger_i;
    end

    // A trigger held low through reset must first fall then rise
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            armed_reg <= 1'h1;
        else if (in_reset_i)
            armed_reg <= trigger_i;
        else if (trigger_prev_reg && !trigger_i)
            armed_reg <= 1'h1;
    end

    assign start_o = armed_reg && !in_reset_i && !trigger_prev_reg && trigger_i;
endmodule : trigger_arm
`default_nettype wire

// >>> tb/adc_reset_range_control_bench.sv
// Self-checking bench joining host and device ends of the span and reset pins
`timescale 1ns/1ps
`default_nettype none
module adc_reset_range_control_bench;
    logic        clk_sys_i = 1'h0;
    logic        rst_i     = 1'h1;
    logic [3:0]  addr_i    = 4'h0;
    logic [31:0] wdata_i   = 32'h0;
    logic        wr_i      = 1'h0;
    logic        rd_i      = 1'h0;
    logic [31:0] rdata_o;
    logic [2:0]  span_active_o;
    logic        sw_mode_o;
    logic [2:0]  converting_o;
    int          fail_count = 0;
    int          n_tests    = 0;

    span_reset_if ifc();
    always #4 clk_sys_i = ~clk_sys_i;

    span_reset_host span_reset_host_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pins(ifc));
    span_reset_device #(.CONV_CYCLES(8)) span_reset_device_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .pins(ifc), .span_active_o(span_active_o), .sw_mode_o(sw_mode_o), .converting_o(converting_o));
    span_reset_chk span_reset_chk_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reset_pin(ifc.reset_pin),
        .hw_sw_select(ifc.hw_sw_select), .span_select(ifc.span_select),
        .conversion_trigger_x(ifc.conversion_trigger_x), .ctrl_span_bits(ifc.ctrl_span_bits),
        .ctrl_span_write(ifc.ctrl_span_write), .busy(ifc.busy));

    task conclude;
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'h1;
        @(posedge clk_sys_i);
        wr_i <= 1'h0;
        #1;
    endtask : wr

    task rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i   <= 1'h1;
        @(posedge clk_sys_i);
        rd_i <= 1'h0;
        #1;
        check(rdata_o, exp);
    endtask : rd

    // Waits for reset pin (sel=1) or busy (sel=0) to reach a level, bounded
    task wait_pin(input logic sel, input logic lvl);
        int i;
        for (i = 0; i < 200; i++)
        begin
            @(posedge clk_sys_i);
            #1;
            if ((sel ? ifc.reset_pin : ifc.busy) === lvl)
                return;
        end
        fail_count++;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, ~lvl, lvl);
        conclude();
    endtask : wait_pin

    // Full trigger pulse, a second control write in mid conversion, span checks
    task conv(input logic [31:0] c0, input logic [31:0] c1, input logic m, input logic [2:0] mid,
              input logic [2:0] fin);
        wr(4'h0, c0);
        wr(4'h0, c0 | 32'h70);
        wait_pin(1'h0, 1'h1);
        wr(4'h0, c1);
        check(ifc.reset_pin, 1'h0);
        check(converting_o, 3'h7);
        if (m)
            check(span_active_o, mid);
        wait_pin(1'h0, 1'h0);
        repeat (3) @(posedge clk_sys_i);
        #1;
        check(span_active_o, fin);
    endtask : conv

    task do_reset(input logic [31:0] c);
        wr(4'h0, c);
        wait_pin(1'h1, 1'h1);
        wait_pin(1'h1, 1'h0);
    endtask : do_reset

    initial
    begin
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'h0;
        wait_pin(1'h1, 1'h0);
        check(sw_mode_o, 1'h0);
        check(span_active_o, 3'h0);
        rd(4'h1, 32'h0);
        rd(4'hf, 32'h0);
        conv(32'h4, 32'h74, 1'h1, 3'h0, 3'h7);
        rd(4'h1, 32'h2);
        rd(4'h1, 32'h0);
        conv(32'h4, 32'h70, 1'h1, 3'h7, 3'h0);
        conv(32'h0, 32'h74, 1'h1, 3'h0, 3'h7);
        do_reset(32'h73);
        check(sw_mode_o, 1'h1);
        wr(4'h2, 32'h5);
        conv(32'h2, 32'h73, 1'h0, 3'h0, 3'h5);
        do_reset(32'h77);
        conv(32'h6, 32'h76, 1'h0, 3'h0, 3'h0);
        do_reset(32'h1);
        check(sw_mode_o, 1'h0);
        wr(4'h0, 32'h70);
        repeat (6) @(posedge clk_sys_i);
        #1;
        check(ifc.busy, 1'h0);
        conv(32'h0, 32'h70, 1'h1, 3'h7, 3'h0);
        conclude();
    end
endmodule : adc_reset_range_control_bench
`default_nettype wire

// >>> tb/span_reset_chk.sv
// Interface checker for the span-select and reset control pair
`timescale 1ns/1ps
`default_nettype none
module span_reset_chk
(
    input wire logic       clk_sys_i,
    input wire logic       rst_i,
    input wire logic       reset_pin,
    input wire logic       hw_sw_select,
    input wire logic       span_select,
    input wire logic [2:0] conversion_trigger_x,
    input wire logic [2:0] ctrl_span_bits,
    input wire logic       ctrl_span_write,
    input wire logic       busy
);
    logic armed_reg;

    // Pair A may start once its trigger was high in reset or has fallen since
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            armed_reg <= 1'h0;
        else if (reset_pin)
            armed_reg <= conversion_trigger_x[0];
        else if ($fell(conversion_trigger_x[0]))
            armed_reg <= 1'h1;
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    reset_quiet_a: assert property (reset_pin |-> ##2 !busy)
        else $error("busy high while device held in reset");
    start_lat_a: assert property ($rose(conversion_trigger_x[0]) && armed_reg && !busy && !reset_pin |-> ##2 busy)
        else $error("armed trigger edge did not start a conversion");
    no_start_a: assert property ($rose(conversion_trigger_x[0]) && !armed_reg && !busy && !reset_pin |-> ##2 !busy)
        else $error("conversion started without a complete trigger pulse");
    busy_cause_a: assert property ($rose(busy) |-> $past(conversion_trigger_x, 2) != $past(conversion_trigger_x, 3))
        else $error("busy rose without a trigger edge");
    busy_len_a: assert property ($rose(busy) |-> busy[*6] ##[1:4] !busy)
        else $error("conversion length out of range");
    rst_gap_a: assert property ($rose(reset_pin) |-> $past(!busy))
        else $error("reset pulse issued during a conversion");
    rst_width_a: assert property ($rose(reset_pin) |-> reset_pin[*8] ##[1:8] !reset_pin)
        else $error("reset pulse width wrong");
    span_pulse_a: assert property (ctrl_span_write |=> !ctrl_span_write)
        else $error("span write strobe longer than one cycle");

    busy_c: cover property ($fell(busy));
    reset_c: cover property ($rose(reset_pin));
    span_c: cover property (ctrl_span_write && hw_sw_select);
endmodule : span_reset_chk
`default_nettype wire
